//--- fpc_pkg.sv
// constants shared by the fuse prom programming controller files
// assumes a 100 MHz mclk and a 32x8 open-collector fuse prom outside
package fpc_pkg;
  // ****************************************************************
  // organisation
  // ****************************************************************
  localparam int WORDS = 32;
  localparam int WBITS = 8;
  localparam int AW = 5;
  localparam logic [4:0] LAST_WORD = 5'h1f;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // ****************************************************************
  // timing, times in ns, counts in mclk cycles
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int SYNC_STAGES = 2;
  localparam int T_ACCESS_NS = 50;
  localparam int ACC_CYC = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SENSE_CYC = ACC_CYC + SYNC_STAGES;
  localparam int T_LEAD_NS = 10000;
  localparam int LEAD_CYC = (T_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_PW0_NS = 500000;
  localparam int T_PW1_NS = 1000000;
  localparam int T_PW2_NS = 5000000;
  localparam int T_PW3_NS = 20000000;
  localparam int REST_MULT = 3;

  // ****************************************************************
  // pulse schedule
  // ****************************************************************
  localparam logic [4:0] GRP0_LAST = 5'h04;
  localparam logic [4:0] GRP1_LAST = 5'h08;
  localparam logic [4:0] GRP2_LAST = 5'h0c;
  localparam logic [4:0] MAX_PULSES = 5'h13;
  localparam logic [1:0] EXTRA_PULSES = 2'h3;
  localparam logic [1:0] LVL_29V = 2'h0;
  localparam logic [1:0] LVL_30V = 2'h1;
  localparam logic [1:0] LVL_33V = 2'h2;

  // ****************************************************************
  // controller states
  // ****************************************************************
  typedef enum logic [10:0] {
    S_IDLE     = 11'h001,
    S_RD_WAIT  = 11'h002,
    S_PG_FETCH = 11'h004,
    S_PG_BIT   = 11'h008,
    S_PG_SENSE = 11'h010,
    S_PG_LEAD  = 11'h020,
    S_PG_BURN  = 11'h040,
    S_PG_REST  = 11'h080,
    S_VF_FETCH = 11'h100,
    S_VF_WAIT  = 11'h200,
    S_VF_CMP   = 11'h400
  } fpc_state_e;
endpackage : fpc_pkg

//--- fpc_image_mem.sv
// image memory: the 32 words that programming should leave in the prom
// assumes writes only while the controller is idle
`timescale 1ns/100ps
module fpc_image_mem
(
  input wire logic mclk,
  input wire logic ce,
  input wire logic we,
  input wire logic [4:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [4:0] raddr,
  output logic [7:0] rdata_q
);
  logic [7:0] mem_q [0:fpc_pkg::WORDS-1];

  always_ff @(posedge mclk)
  begin
    if (ce)
    begin
      if (we)
      begin
        mem_q[waddr] <= wdata;
      end
      rdata_q <= mem_q[raddr];
    end
  end
endmodule : fpc_image_mem

//--- fpc_ctrl.sv
// host controller that reads and field-programs a 32x8 fuse prom
// assumes board drivers turn the level outputs into supply and pulse
// voltages, and that read_lines arrive asynchronously from the pins
`timescale 1ns/100ps
// Notes on behaviour
// R1: prom holds 32 eight-bit words, one picked by the 5-bit address.
// R2: all 8 bits of a word appear together while gate is low.
// R3: gate high inhibits the read lines; none pulls low.
// R4: read lines are open collector; low means zero, released means one.
// R5: an unprogrammed bit reads as one.
// R6: raise supply to programming level, then present the word address; the code raises vcc_prog and sets the address in the same cycle.
// R7: hold the gate high before and during the pulse sequence.
// R8: gate program pulse first, burn pulse on the read line after.
// R9: burn pulses go to one read line at a time only.
// R10: a blown fuse reads zero for good.
// R11: once a bit reads zero, give it three more pulses.
// R12: after programming, read every word with gate low and compare.
// R13: prom read path is combinational with a fixed access delay.
module fpc_ctrl
#(
  parameter int PW0_CYC = fpc_pkg::T_PW0_NS / fpc_pkg::CLK_PERIOD_NS,
  parameter int PW1_CYC = fpc_pkg::T_PW1_NS / fpc_pkg::CLK_PERIOD_NS,
  parameter int PW2_CYC = fpc_pkg::T_PW2_NS / fpc_pkg::CLK_PERIOD_NS,
  parameter int PW3_CYC = fpc_pkg::T_PW3_NS / fpc_pkg::CLK_PERIOD_NS
)
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  input wire logic cmd_read,
  input wire logic [4:0] cmd_addr,
  input wire logic cmd_program,
  input wire logic img_we,
  input wire logic [4:0] img_addr,
  input wire logic [7:0] img_data,
  input wire logic [7:0] read_lines,
  output logic [4:0] word_select_inputs,
  output logic gate_n,
  output logic gate_program_pulse,
  output logic [1:0] gate_level,
  output logic vcc_prog,
  output logic [7:0] burn_pulse,
  output logic busy,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic done,
  output logic prog_fail,
  output logic verify_mismatch
);
  // ****************************************************************
  // state
  // ****************************************************************
  fpc_pkg::fpc_state_e state_q, state_d;
  logic [31:0] cnt_q, cnt_d;
  logic [4:0] word_q, word_d;
  logic [2:0] bit_q, bit_d;
  logic [4:0] pulses_q, pulses_d;
  logic [1:0] extra_q, extra_d;
  logic in_extra_q, in_extra_d;
  logic gate_n_q, gate_n_d;
  logic gpp_q, gpp_d;
  logic [1:0] lvl_q, lvl_d;
  logic vcc_q, vcc_d;
  logic [7:0] burn_q, burn_d;
  logic busy_q, busy_d;
  logic [7:0] rdd_q, rdd_d;
  logic rdv_q, rdv_d;
  logic done_q, done_d;
  logic fail_q, fail_d;
  logic mism_q, mism_d;
  logic [7:0] rl_s1_q, rl_s2_q;
  logic [7:0] img_rdata;
  logic [31:0] cur_w;
  logic [1:0] cur_lvl;
  logic adv;
  logic start;

  // ****************************************************************
  // intended image
  // ****************************************************************
  fpc_image_mem u_img
  (
    .mclk(mclk),
    .ce(ce),
    .we(img_we && (state_q == fpc_pkg::S_IDLE)),
    .waddr(img_addr),
    .wdata(img_data),
    .raddr(word_q),
    .rdata_q(img_rdata)
  );

  // ****************************************************************
  // pulse width and gate level per pulse number
  // ****************************************************************
  always_comb
  begin
    if (pulses_q <= fpc_pkg::GRP0_LAST)
    begin
      cur_w = 32'(PW0_CYC);
      cur_lvl = fpc_pkg::LVL_29V;
    end
    else if (pulses_q <= fpc_pkg::GRP1_LAST)
    begin
      cur_w = 32'(PW1_CYC);
      cur_lvl = fpc_pkg::LVL_29V;
    end
    else if (pulses_q <= fpc_pkg::GRP2_LAST)
    begin
      cur_w = 32'(PW2_CYC);
      cur_lvl = fpc_pkg::LVL_30V;
    end
    else
    begin
      cur_w = 32'(PW3_CYC);
      cur_lvl = fpc_pkg::LVL_33V;
    end
  end

  // ****************************************************************
  // sequencer next state
  // ****************************************************************
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    word_d = word_q;
    bit_d = bit_q;
    pulses_d = pulses_q;
    extra_d = extra_q;
    in_extra_d = in_extra_q;
    gate_n_d = gate_n_q;
    gpp_d = gpp_q;
    lvl_d = lvl_q;
    vcc_d = vcc_q;
    burn_d = burn_q;
    busy_d = busy_q;
    rdd_d = rdd_q;
    rdv_d = 1'b0;
    done_d = 1'b0;
    fail_d = fail_q;
    mism_d = mism_q;
    adv = 1'b0;
    start = 1'b0;
    case (state_q)
      fpc_pkg::S_IDLE:
      begin
        if (cmd_read)
        begin
          // R1: word picked by address alone
          word_d = cmd_addr;
          gate_n_d = 1'b0;
          cnt_d = 32'(fpc_pkg::SENSE_CYC);
          busy_d = 1'b1;
          state_d = fpc_pkg::S_RD_WAIT;
        end
        else if (cmd_program)
        begin
          // R6: supply up together with the first address
          vcc_d = 1'b1;
          word_d = 5'h00;
          bit_d = 3'h0;
          // R7: gate held high into the sequence
          gate_n_d = 1'b1;
          fail_d = 1'b0;
          mism_d = 1'b0;
          busy_d = 1'b1;
          state_d = fpc_pkg::S_PG_FETCH;
        end
      end
      fpc_pkg::S_RD_WAIT:
      begin
        if (cnt_q != 32'h0)
        begin
          cnt_d = cnt_q - 32'h1;
        end
        else
        begin
          // R2: whole word sampled at once after access delay
          // R13: wait covers access time plus synchroniser
          rdd_d = rl_s2_q;
          rdv_d = 1'b1;
          gate_n_d = 1'b1;
          busy_d = 1'b0;
          state_d = fpc_pkg::S_IDLE;
        end
      end
      fpc_pkg::S_PG_FETCH:
      begin
        // image read data lags the address by one cycle
        pulses_d = 5'h00;
        in_extra_d = 1'b0;
        state_d = fpc_pkg::S_PG_BIT;
      end
      fpc_pkg::S_PG_BIT:
      begin
        // R5: bits meant to stay one need no pulse
        if (img_rdata[bit_q])
        begin
          adv = 1'b1;
        end
        else
        begin
          gate_n_d = 1'b0;
          cnt_d = 32'(fpc_pkg::SENSE_CYC);
          state_d = fpc_pkg::S_PG_SENSE;
        end
      end
      fpc_pkg::S_PG_SENSE:
      begin
        if (cnt_q != 32'h0)
        begin
          cnt_d = cnt_q - 32'h1;
        end
        else
        begin
          gate_n_d = 1'b1;
          // R4: a pulled-low line is a zero
          if (!rl_s2_q[bit_q])
          begin
            if (pulses_q == 5'h00)
            begin
              adv = 1'b1;
            end
            else
            begin
              // R11: three more pulses after the change
              extra_d = fpc_pkg::EXTRA_PULSES;
              in_extra_d = 1'b1;
              start = 1'b1;
            end
          end
          else if (pulses_q == fpc_pkg::MAX_PULSES)
          begin
            fail_d = 1'b1;
            adv = 1'b1;
          end
          else
          begin
            pulses_d = pulses_q + 5'h01;
            start = 1'b1;
          end
        end
      end
      fpc_pkg::S_PG_LEAD:
      begin
        // pulse count has settled by now, so the level tracks it
        lvl_d = cur_lvl;
        if (cnt_q != 32'h0)
        begin
          cnt_d = cnt_q - 32'h1;
        end
        else
        begin
          // R8: burn only once the gate pulse stands
          // R9: one line of the word at a time
          burn_d = 8'h01 << bit_q;
          cnt_d = cur_w;
          state_d = fpc_pkg::S_PG_BURN;
        end
      end
      fpc_pkg::S_PG_BURN:
      begin
        if (cnt_q != 32'h0)
        begin
          cnt_d = cnt_q - 32'h1;
        end
        else
        begin
          burn_d = 8'h00;
          gpp_d = 1'b0;
          // rest keeps the pulse duty cycle at about a quarter
          cnt_d = 32'(fpc_pkg::REST_MULT) * (cur_w + 32'(fpc_pkg::LEAD_CYC));
          state_d = fpc_pkg::S_PG_REST;
        end
      end
      fpc_pkg::S_PG_REST:
      begin
        if (cnt_q != 32'h0)
        begin
          cnt_d = cnt_q - 32'h1;
        end
        else if (in_extra_q)
        begin
          // R11: count the extra pulses down
          extra_d = extra_q - 2'h1;
          if (extra_q == 2'h1)
          begin
            in_extra_d = 1'b0;
            adv = 1'b1;
          end
          else
          begin
            start = 1'b1;
          end
        end
        else
        begin
          // R10: look again for the zero of a blown fuse
          gate_n_d = 1'b0;
          cnt_d = 32'(fpc_pkg::SENSE_CYC);
          state_d = fpc_pkg::S_PG_SENSE;
        end
      end
      fpc_pkg::S_VF_FETCH:
      begin
        // R12: gate low for the verify read
        gate_n_d = 1'b0;
        cnt_d = 32'(fpc_pkg::SENSE_CYC);
        state_d = fpc_pkg::S_VF_WAIT;
      end
      fpc_pkg::S_VF_WAIT:
      begin
        if (cnt_q != 32'h0)
        begin
          cnt_d = cnt_q - 32'h1;
        end
        else
        begin
          state_d = fpc_pkg::S_VF_CMP;
        end
      end
      fpc_pkg::S_VF_CMP:
      begin
        // R12: every bit against the image
        if (rl_s2_q != img_rdata)
        begin
          mism_d = 1'b1;
        end
        if (word_q == fpc_pkg::LAST_WORD)
        begin
          gate_n_d = 1'b1;
          busy_d = 1'b0;
          done_d = 1'b1;
          word_d = 5'h00;
          state_d = fpc_pkg::S_IDLE;
        end
        else
        begin
          word_d = word_q + 5'h01;
          state_d = fpc_pkg::S_VF_FETCH;
        end
      end
      default:
      begin
        state_d = fpc_pkg::S_IDLE;
      end
    endcase
    if (start)
    begin
      // R8: program pulse on the gate comes first
      gpp_d = 1'b1;
      lvl_d = cur_lvl;
      cnt_d = 32'(fpc_pkg::LEAD_CYC);
      state_d = fpc_pkg::S_PG_LEAD;
    end
    if (adv)
    begin
      if (bit_q != fpc_pkg::LAST_BIT)
      begin
        bit_d = bit_q + 3'h1;
        pulses_d = 5'h00;
        state_d = fpc_pkg::S_PG_BIT;
      end
      else if (word_q != fpc_pkg::LAST_WORD)
      begin
        bit_d = 3'h0;
        word_d = word_q + 5'h01;
        state_d = fpc_pkg::S_PG_FETCH;
      end
      else
      begin
        // supply back to normal before the verify pass
        vcc_d = 1'b0;
        bit_d = 3'h0;
        word_d = 5'h00;
        state_d = fpc_pkg::S_VF_FETCH;
      end
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      state_q <= fpc_pkg::S_IDLE;
      cnt_q <= 32'h0;
      word_q <= 5'h00;
      bit_q <= 3'h0;
      pulses_q <= 5'h00;
      extra_q <= 2'h0;
      in_extra_q <= 1'b0;
      gate_n_q <= 1'b1;
      gpp_q <= 1'b0;
      lvl_q <= fpc_pkg::LVL_29V;
      vcc_q <= 1'b0;
      burn_q <= 8'h00;
      busy_q <= 1'b0;
      rdd_q <= 8'h00;
      rdv_q <= 1'b0;
      done_q <= 1'b0;
      fail_q <= 1'b0;
      mism_q <= 1'b0;
      rl_s1_q <= 8'hff;
      rl_s2_q <= 8'hff;
    end
    else if (ce)
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      word_q <= word_d;
      bit_q <= bit_d;
      pulses_q <= pulses_d;
      extra_q <= extra_d;
      in_extra_q <= in_extra_d;
      gate_n_q <= gate_n_d;
      gpp_q <= gpp_d;
      lvl_q <= lvl_d;
      vcc_q <= vcc_d;
      burn_q <= burn_d;
      busy_q <= busy_d;
      rdd_q <= rdd_d;
      rdv_q <= rdv_d;
      done_q <= done_d;
      fail_q <= fail_d;
      mism_q <= mism_d;
      rl_s1_q <= read_lines;
      rl_s2_q <= rl_s1_q;
    end
  end

  assign word_select_inputs = word_q;
  assign gate_n = gate_n_q;
  assign gate_program_pulse = gpp_q;
  assign gate_level = lvl_q;
  assign vcc_prog = vcc_q;
  assign burn_pulse = burn_q;
  assign busy = busy_q;
  assign rd_data = rdd_q;
  assign rd_valid = rdv_q;
  assign done = done_q;
  assign prog_fail = fail_q;
  assign verify_mismatch = mism_q;
endmodule : fpc_ctrl

//--- fpc_ctrl_sva.sv
// port-level checks for the fuse prom programming controller
// assumes one mclk domain and a synchronous active-high reset
`timescale 1ns/100ps
module fpc_ctrl_sva
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  input wire logic cmd_read,
  input wire logic [4:0] word_select_inputs,
  input wire logic gate_n,
  input wire logic gate_program_pulse,
  input wire logic vcc_prog,
  input wire logic [7:0] burn_pulse,
  input wire logic busy,
  input wire logic rd_valid,
  input wire logic done
);
  // ******************************
  // checks
  // ******************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  property p_burn_one;
    $onehot0(burn_pulse);
  endproperty
  a_burn_one: assert property (p_burn_one)
    else $error("burn pulse on several lines");

  property p_burn_gated;
    |burn_pulse |-> gate_program_pulse && gate_n;
  endproperty
  a_burn_gated: assert property (p_burn_gated)
    else $error("burn pulse without gate program pulse");

  // lead time is long, so eight cycles back is a safe minimum
  property p_burn_lead;
    $rose(|burn_pulse) |-> $past(gate_program_pulse, 8);
  endproperty
  a_burn_lead: assert property (p_burn_lead)
    else $error("burn pulse came too soon after gate pulse");

  // shortest width the bench uses is four cycles plus one
  property p_burn_width;
    $rose(|burn_pulse) |-> (|burn_pulse) [*5];
  endproperty
  a_burn_width: assert property (p_burn_width)
    else $error("burn pulse too short");

  property p_drop_together;
    $fell(|burn_pulse) |-> $fell(gate_program_pulse);
  endproperty
  a_drop_together: assert property (p_drop_together)
    else $error("burn and gate pulses did not end together");

  property p_gate_high;
    gate_program_pulse |-> gate_n && vcc_prog;
  endproperty
  a_gate_high: assert property (p_gate_high)
    else $error("gate low or supply low during pulse");

  property p_addr_held;
    gate_program_pulse && $past(gate_program_pulse)
      |-> $stable(word_select_inputs);
  endproperty
  a_addr_held: assert property (p_addr_held)
    else $error("word address moved during pulse");

  property p_read_walk;
    !busy && ce && cmd_read |=> busy && !gate_n ##8 rd_valid && gate_n;
  endproperty
  a_read_walk: assert property (p_read_walk)
    else $error("read answer late or gate left low");

  property p_done_pulse;
    done |-> !vcc_prog && !gate_program_pulse ##1 !done;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("verify ended at programming supply");
endmodule : fpc_ctrl_sva

bind fpc_ctrl fpc_ctrl_sva u_sva (.mclk(mclk), .reset(reset), .ce(ce),
  .cmd_read(cmd_read), .word_select_inputs(word_select_inputs),
  .gate_n(gate_n), .gate_program_pulse(gate_program_pulse),
  .vcc_prog(vcc_prog), .burn_pulse(burn_pulse), .busy(busy),
  .rd_valid(rd_valid), .done(done));

//--- fpc_prom_model.sv
// behavioural 32x8 fuse prom facing the controller
// assumes burn requests are levels that change just after mclk edges
`timescale 1ns/100ps
module fpc_prom_model
#(
  parameter int NEED = 2
)
(
  input wire logic mclk,
  input wire logic [4:0] word_select_inputs,
  input wire logic gate_n,
  input wire logic gate_program_pulse,
  input wire logic [7:0] burn_pulse,
  output logic [7:0] read_lines
);
  logic [7:0] fuse_q [32];
  int hits_q [32][8];
  logic [7:0] prev_q;

  initial
  begin
    prev_q = 8'h00;
    for (int w = 0; w < 32; w++)
    begin
      fuse_q[w] = 8'hff;
      for (int b = 0; b < 8; b++)
        hits_q[w][b] = 0;
    end
  end

  // opened fuse never closes; a fuse needs NEED pulses
  always @(posedge mclk)
  begin
    prev_q <= burn_pulse;
    for (int b = 0; b < 8; b++)
      if (burn_pulse[b] && !prev_q[b] && gate_program_pulse && gate_n)
      begin
        hits_q[word_select_inputs][b] <= hits_q[word_select_inputs][b] + 1;
        if (hits_q[word_select_inputs][b] + 1 >= NEED)
          fuse_q[word_select_inputs][b] <= 1'b0;
      end
  end

  // released lines read high through the pull-up
  assign #40 read_lines = gate_n ? 8'hff : fuse_q[word_select_inputs];
endmodule : fpc_prom_model

//--- fpc_ctrl_bench.sv
// self-checking bench for the fuse prom programming controller
// assumes the prom model on read_lines; ce is held high throughout
`timescale 1ns/100ps
module fpc_ctrl_bench;
  localparam int NEED = 2;
  logic mclk, reset, ce, cmd_read, cmd_program, img_we;
  logic [4:0] cmd_addr, img_addr, word_select_inputs;
  logic [7:0] img_data, read_lines, burn_pulse, rd_data, burn_prev;
  logic [1:0] gate_level;
  logic gate_n, gate_program_pulse, vcc_prog, busy, rd_valid, done;
  logic prog_fail, verify_mismatch;
  int miscompares, samples_checked, pulses;

  fpc_ctrl #(.PW0_CYC(4), .PW1_CYC(6), .PW2_CYC(8), .PW3_CYC(10)) dut (
    .mclk(mclk), .reset(reset), .ce(ce), .cmd_read(cmd_read),
    .cmd_addr(cmd_addr), .cmd_program(cmd_program), .img_we(img_we),
    .img_addr(img_addr), .img_data(img_data), .read_lines(read_lines),
    .word_select_inputs(word_select_inputs), .gate_n(gate_n),
    .gate_program_pulse(gate_program_pulse), .gate_level(gate_level),
    .vcc_prog(vcc_prog), .burn_pulse(burn_pulse), .busy(busy),
    .rd_data(rd_data), .rd_valid(rd_valid), .done(done),
    .prog_fail(prog_fail), .verify_mismatch(verify_mismatch));

  fpc_prom_model #(.NEED(NEED)) u_prom (.mclk(mclk),
    .word_select_inputs(word_select_inputs), .gate_n(gate_n),
    .gate_program_pulse(gate_program_pulse), .burn_pulse(burn_pulse),
    .read_lines(read_lines));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // counts separate burn pulses, whichever line they hit
  always @(posedge mclk)
  begin
    burn_prev <= burn_pulse;
    if ((|burn_pulse) && !(|burn_prev))
    begin
      pulses++;
      // early pulses run at the lowest gate level
      check("gate_level", {6'h00, gate_level}, {6'h00, fpc_pkg::LVL_29V});
    end
  end

  // ******************************
  // shared tasks
  // ******************************
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  task automatic read_check(input logic [4:0] a, input logic [7:0] exp);
    int n;
    @(posedge mclk);
    cmd_addr <= a;
    cmd_read <= 1'b1;
    @(posedge mclk);
    cmd_read <= 1'b0;
    n = 0;
    do
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    while (rd_valid !== 1'b1 && n < 20);
    check("read_latency", 8'(n), 8'h08);
    check("read_word", rd_data, exp);
  endtask : read_check

  // word 31 always asks for bit 7 blown; word 3 is the variable one
  task automatic load_image(input logic [7:0] w3);
    @(posedge mclk);
    img_we <= 1'b1;
    for (int w = 0; w < 32; w++)
    begin
      img_addr <= 5'(w);
      img_data <= (w == 3) ? w3 : ((w == 31) ? 8'h7f : 8'hff);
      @(posedge mclk);
    end
    img_we <= 1'b0;
  endtask : load_image

  task automatic program_run(input logic exp_mm, input int exp_pulses);
    int n;
    @(posedge mclk);
    pulses = 0;
    cmd_program <= 1'b1;
    @(posedge mclk);
    cmd_program <= 1'b0;
    n = 0;
    do
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    while (done !== 1'b1 && n < 60000);
    check("done", {7'h00, done}, 8'h01);
    check("prog_fail", {7'h00, prog_fail}, 8'h00);
    check("verify_mismatch", {7'h00, verify_mismatch}, {7'h00, exp_mm});
    check("pulses", 8'(pulses), 8'(exp_pulses));
  endtask : program_run

  // ******************************
  // scenarios
  // ******************************
  task automatic t_fresh();
    check("gate_after_reset", {7'h00, gate_n}, 8'h01);
    read_check(5'h00, 8'hff);
    read_check(5'h1f, 8'hff);
    read_check(5'h03, 8'hff);
  endtask : t_fresh

  // two bits blown: each takes NEED pulses plus three more
  task automatic t_program();
    load_image(8'hfe);
    program_run(1'b0, 2 * (NEED + 3));
    read_check(5'h03, 8'hfe);
    read_check(5'h1f, 8'h7f);
    read_check(5'h1e, 8'hff);
  endtask : t_program

  // blown bits are skipped, and a word that cannot return fails verify
  task automatic t_verify_fail();
    load_image(8'hff);
    program_run(1'b1, 0);
    read_check(5'h03, 8'hfe);
  endtask : t_verify_fail

  initial
  begin
    reset = 1'b1;
    ce = 1'b1;
    cmd_read = 1'b0;
    cmd_addr = 5'h00;
    cmd_program = 1'b0;
    img_we = 1'b0;
    img_addr = 5'h00;
    img_data = 8'h00;
    burn_prev = 8'h00;
    miscompares = 0;
    samples_checked = 0;
    pulses = 0;
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    t_fresh();
    t_program();
    t_verify_fail();
    conclude();
  end

  // about 42000 cycles are expected for the whole run
  initial
  begin
    repeat (100000) @(posedge mclk);
    miscompares++;
    conclude();
  end
endmodule : fpc_ctrl_bench
